// file: rtl/supervisor_defs.svh
// Constants for the reset and watchdog supervisor: register offsets,
// field positions, reset values and timing figures.
// Assumes a 100 MHz clock; included by its bare name.
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

// Clock period in ns
`define SUP_CLK_PERIOD_NS      10
// Timing scale per nF of programming capacitance, in ns
`define SUP_UPPER_NS_PER_NF    18200000
`define SUP_LOWER_NS_PER_NF    588000
`define SUP_DELAY_NS_PER_NF    2300000
// Capacitance in nF that the reset values stand for
`define SUP_DEFAULT_CAP_NF     1

// Register byte offsets
`define SUP_REG_DELAY          8'h00
`define SUP_REG_UPPER          8'h04
`define SUP_REG_LOWER          8'h08
`define SUP_REG_STATUS         8'h0c
`define SUP_REG_MASK           8'h10
`define SUP_REG_STATE          8'h14

// Event bits of the status and mask registers
`define SUP_EV_EARLY           0
`define SUP_EV_LATE            1
`define SUP_EV_RST_ASSERT      2
`define SUP_EV_RST_RELEASE     3
`define SUP_EV_W               4

// Bits of the state register
`define SUP_ST_RESET_N         0
`define SUP_ST_FAULT_N         1
`define SUP_ST_INHIBIT         2
`define SUP_ST_TIMEOUT_MODE    3
`define SUP_ST_OUT_GOOD        4
`define SUP_ST_ENABLED         5

`define SUP_MASK_RESET         4'h0

`endif

// file: rtl/supervisor_pkg.sv
// Types shared by the reset and watchdog supervisor.
// Assumes nothing beyond a SystemVerilog compiler.
package supervisor_pkg;

	typedef enum logic [1:0] {
		PorHold,
		PorRun
	} por_state_t;

	typedef enum logic [1:0] {
		WdIdle,
		WdWatch,
		WdFault
	} wd_state_t;

endpackage : supervisor_pkg

// file: rtl/input_sync.sv
// Three-stage synchroniser for pins from outside the clock domain.
// A new level is accepted once the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none

module input_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] pinIn,
	output var  logic [WIDTH-1:0] levelOut
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] stage2_r;
	logic [WIDTH-1:0] stage3_r;

	// First stage feeds only the second; filtering looks at stages two and three
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_r   <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
			levelOut <= '0;
		end else begin
			meta_r   <= pinIn;
			stage2_r <= meta_r;
			stage3_r <= stage2_r;
			levelOut <= (stage2_r & stage3_r) | (levelOut & (stage2_r | stage3_r));
		end
	end

endmodule : input_sync

`default_nettype wire

// file: rtl/power_on_reset_watchdog_supervisor.sv
// Power-on reset and watchdog supervisor with an APB register slave.
// Assumes pins arrive asynchronously and a 100 MHz clk with async rstn.
//
// Functional notes
// R1 - Inhibit high disables watchdog checking and holds the fault output high.
// R2 - Mode select low gives window mode, high gives timeout mode.
// R3 - Window mode: falling kick before lower boundary elapsed drives fault low.
// R4 - Window mode: no falling kick within upper boundary drives fault low.
// R5 - Timeout mode: only no kick transition within upper boundary is a fault.
// R6 - A fault pulses the fault output low for the reset delay.
// R7 - Monitoring pauses while fault is low, timing restarts after release.
// R8 - After output is good, reset output stays low for the reset delay.
// R9 - Upper and lower boundary periods are programmable durations.
// R10 - Reset delay is a programmable duration.
// R11 - Shutdown input low shuts all logic down until it rises again; here only the reset timer and watchdog stop.
// R12 - Reset output asserts whenever the output falls below its threshold.
// R13 - Fault output releases when its timer ends or reset output asserts.
// R14 - Processor kicks before upper boundary, spaced no closer than lower.
// R15 - Delay and boundaries are clock counters loaded from configuration.
`timescale 1ns/1ns
`default_nettype none
`include "supervisor_defs.svh"

module power_on_reset_watchdog_supervisor #(
	parameter int          CNT_W         = 32,
	parameter logic [31:0] DELAY_DEFAULT = 32'(`SUP_DELAY_NS_PER_NF / `SUP_CLK_PERIOD_NS
		* `SUP_DEFAULT_CAP_NF),
	parameter logic [31:0] UPPER_DEFAULT = 32'(`SUP_UPPER_NS_PER_NF / `SUP_CLK_PERIOD_NS
		* `SUP_DEFAULT_CAP_NF),
	parameter logic [31:0] LOWER_DEFAULT = 32'(`SUP_LOWER_NS_PER_NF / `SUP_CLK_PERIOD_NS
		* `SUP_DEFAULT_CAP_NF)
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Pins from the system
	input  wire logic        watchdogInhibit,
	input  wire logic        windowTimeoutSel,
	input  wire logic        watchdogKickInput,
	input  wire logic        outputGood,
	input  wire logic        shutdownLockoutInput,
	// Supervisor outputs
	output var  logic        resetN,
	output var  logic        watchdogFaultN,
	output var  logic        irq
);

	// Synchronised pin levels
	logic [4:0] pinLevel;
	logic       inhibit;
	logic       timeoutMode;
	logic       kickLevel;
	logic       outGood;
	logic       enabled;

	input_sync #(
		.WIDTH (5)
	) u_sync (
		.clk      (clk),
		.rstn     (rstn),
		.pinIn    ({shutdownLockoutInput, outputGood, watchdogKickInput,
			windowTimeoutSel, watchdogInhibit}),
		.levelOut (pinLevel)
	);

	assign inhibit     = pinLevel[0];
	assign timeoutMode = pinLevel[1];
	assign kickLevel   = pinLevel[2];
	assign outGood     = pinLevel[3];
	assign enabled     = pinLevel[4];

	// Registers
	logic [CNT_W-1:0]       delay_r;
	logic [CNT_W-1:0]       upper_r;
	logic [CNT_W-1:0]       lower_r;
	logic [`SUP_EV_W-1:0]   status_r;
	logic [`SUP_EV_W-1:0]   mask_r;
	logic [`SUP_EV_W-1:0]   events;

	supervisor_pkg::por_state_t porState_r;
	supervisor_pkg::wd_state_t  wdState_r;
	logic [CNT_W-1:0]           porCnt_r;
	logic [CNT_W-1:0]           wdCnt_r;
	logic                       kickPrev_r;
	logic                       modePrev_r;

	// A programmed zero would make a period vanish; one cycle is the floor
	function automatic logic [CNT_W-1:0] atLeastOne(input logic [CNT_W-1:0] v);
		atLeastOne = (v == '0) ? CNT_W'(1) : v;
	endfunction : atLeastOne

	// Kick events derived from the synchronised level
	logic kickAny;
	logic kickFall;
	logic kickEvent;
	logic modeChanged;

	assign kickAny     = kickLevel ^ kickPrev_r;
	assign kickFall    = kickPrev_r & ~kickLevel;
	assign kickEvent   = timeoutMode ? kickAny : kickFall;  // see R2
	assign modeChanged = timeoutMode ^ modePrev_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			kickPrev_r <= 1'b0;
			modePrev_r <= 1'b0;
		end else begin
			kickPrev_r <= kickLevel;
			modePrev_r <= timeoutMode;
		end
	end

	// APB access decode
	logic       apbAccess;
	logic       apbWrite;
	logic       apbRead;
	logic       addrHit;
	logic [7:0] stateWord;

	assign apbAccess = psel & penable & ~pready;
	assign apbWrite  = psel & penable & pready & pwrite & ~pslverr;
	assign apbRead   = apbAccess & ~pwrite;

	always_comb begin
		case (paddr)
			`SUP_REG_DELAY,
			`SUP_REG_UPPER,
			`SUP_REG_LOWER,
			`SUP_REG_STATUS,
			`SUP_REG_MASK,
			`SUP_REG_STATE: addrHit = 1'b1;
			default:        addrHit = 1'b0;
		endcase
	end

	always_comb begin
		stateWord                        = '0;
		stateWord[`SUP_ST_RESET_N]       = resetN;
		stateWord[`SUP_ST_FAULT_N]       = watchdogFaultN;
		stateWord[`SUP_ST_INHIBIT]       = inhibit;
		stateWord[`SUP_ST_TIMEOUT_MODE]  = timeoutMode;
		stateWord[`SUP_ST_OUT_GOOD]      = outGood;
		stateWord[`SUP_ST_ENABLED]       = enabled;
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= apbAccess;
			pslverr <= apbAccess & ~addrHit;
			prdata  <= '0;
			if (apbRead) begin
				case (paddr)
					`SUP_REG_DELAY:  prdata <= 32'(delay_r);
					`SUP_REG_UPPER:  prdata <= 32'(upper_r);
					`SUP_REG_LOWER:  prdata <= 32'(lower_r);
					`SUP_REG_STATUS: prdata <= 32'(status_r);
					`SUP_REG_MASK:   prdata <= 32'(mask_r);
					`SUP_REG_STATE:  prdata <= 32'(stateWord);
					default:         prdata <= '0;
				endcase
			end
		end
	end

	// Period registers stand in for the programming capacitors
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			delay_r <= CNT_W'(DELAY_DEFAULT);  // see R10
			upper_r <= CNT_W'(UPPER_DEFAULT);  // see R9
			lower_r <= CNT_W'(LOWER_DEFAULT);  // see R9
			mask_r  <= `SUP_MASK_RESET;
		end else if (apbWrite) begin
			case (paddr)
				`SUP_REG_DELAY: delay_r <= pwdata[CNT_W-1:0];  // see R15
				`SUP_REG_UPPER: upper_r <= pwdata[CNT_W-1:0];  // see R15
				`SUP_REG_LOWER: lower_r <= pwdata[CNT_W-1:0];  // see R15
				`SUP_REG_MASK:  mask_r  <= pwdata[`SUP_EV_W-1:0];
				default:        mask_r  <= mask_r;
			endcase
		end
	end

	// Power-on reset timer; shutdown holds it as after power-up
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			porState_r <= supervisor_pkg::PorHold;
			porCnt_r   <= '0;
			resetN     <= 1'b0;
		end else if (!enabled) begin
			porState_r <= supervisor_pkg::PorHold;  // see R11
			porCnt_r   <= '0;
			resetN     <= 1'b0;
		end else begin
			case (porState_r)
				supervisor_pkg::PorHold: begin
					if (!outGood) begin
						porCnt_r <= '0;
					end else if (porCnt_r >= atLeastOne(delay_r) - CNT_W'(1)) begin
						porState_r <= supervisor_pkg::PorRun;  // see R8
						resetN     <= 1'b1;
						porCnt_r   <= '0;
					end else begin
						porCnt_r <= porCnt_r + CNT_W'(1);  // see R8
					end
				end
				supervisor_pkg::PorRun: begin
					if (!outGood) begin
						porState_r <= supervisor_pkg::PorHold;  // see R12
						resetN     <= 1'b0;
					end
				end
				default: begin
					porState_r <= supervisor_pkg::PorHold;
					resetN     <= 1'b0;
				end
			endcase
		end
	end

	// Watchdog: one counter times the boundaries and then the fault pulse
	logic earlyFault;
	logic lateFault;
	logic wdStart;
	logic fallSeen_r;

	assign earlyFault = ~timeoutMode & kickFall & fallSeen_r
		& (wdCnt_r < lower_r);  // see R3
	assign lateFault  = ~kickEvent
		& (wdCnt_r >= atLeastOne(upper_r) - CNT_W'(1));  // see R4 see R5
	assign wdStart    = enabled & ~inhibit & resetN;

	// Early check needs a previous falling edge; a restart or mode change forgets it,
	// so the first kick after a fault pulse is never taken as too early
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fallSeen_r <= 1'b0;
		end else if (!wdStart || wdState_r != supervisor_pkg::WdWatch || modeChanged) begin
			fallSeen_r <= 1'b0;
		end else if (earlyFault || lateFault) begin
			fallSeen_r <= 1'b0;
		end else if (kickFall) begin
			fallSeen_r <= 1'b1;  // see R3
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdState_r      <= supervisor_pkg::WdIdle;
			wdCnt_r        <= '0;
			watchdogFaultN <= 1'b1;
		end else if (!wdStart) begin
			// Inhibit, shutdown or reset output low all stop the watchdog
			wdState_r      <= supervisor_pkg::WdIdle;  // see R1 see R11
			wdCnt_r        <= '0;
			watchdogFaultN <= 1'b1;  // see R13
		end else begin
			case (wdState_r)
				supervisor_pkg::WdIdle: begin
					wdState_r <= supervisor_pkg::WdWatch;
					wdCnt_r   <= '0;
				end
				supervisor_pkg::WdWatch: begin
					if (modeChanged) begin
						wdCnt_r <= '0;  // see R2
					end else if (earlyFault || lateFault) begin
						wdState_r      <= supervisor_pkg::WdFault;  // see R6
						wdCnt_r        <= '0;
						watchdogFaultN <= 1'b0;
					end else if (kickEvent) begin
						wdCnt_r <= '0;  // see R5
					end else begin
						wdCnt_r <= wdCnt_r + CNT_W'(1);
					end
				end
				supervisor_pkg::WdFault: begin
					// Kicks are ignored until the pulse ends
					if (wdCnt_r >= atLeastOne(delay_r) - CNT_W'(1)) begin
						wdState_r      <= supervisor_pkg::WdWatch;  // see R7
						wdCnt_r        <= '0;
						watchdogFaultN <= 1'b1;  // see R13
					end else begin
						wdCnt_r <= wdCnt_r + CNT_W'(1);  // see R6
					end
				end
				default: begin
					wdState_r      <= supervisor_pkg::WdIdle;
					watchdogFaultN <= 1'b1;
				end
			endcase
		end
	end

	// Interrupt events; each is a single cycle
	logic inWatch;

	assign inWatch = wdStart & (wdState_r == supervisor_pkg::WdWatch) & ~modeChanged;

	always_comb begin
		events                      = '0;
		events[`SUP_EV_EARLY]       = inWatch & earlyFault;
		events[`SUP_EV_LATE]        = inWatch & ~earlyFault & lateFault;
		events[`SUP_EV_RST_ASSERT]  = enabled & (porState_r == supervisor_pkg::PorRun)
			& ~outGood;
		events[`SUP_EV_RST_RELEASE] = enabled & (porState_r == supervisor_pkg::PorHold)
			& outGood & (porCnt_r >= atLeastOne(delay_r) - CNT_W'(1));
	end

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status_r <= '0;
		end else if (apbWrite && paddr == `SUP_REG_STATUS) begin
			status_r <= (status_r & ~pwdata[`SUP_EV_W-1:0]) | events;
		end else begin
			status_r <= status_r | events;
		end
	end

	// Level interrupt, registered so it leaves straight from a flip-flop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_r & mask_r);
		end
	end

endmodule : power_on_reset_watchdog_supervisor

`default_nettype wire

// file: bench/kick_source.sv
// Processor model that kicks the watchdog pin.
// Assumes the bench sets the half period and stops it to starve the watchdog.
`timescale 1ns/1ns
`default_nettype none

module kick_source (
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic [7:0] halfPeriod,
	output var  logic       kick
);
	logic [7:0] cnt_r;

	// Toggle every halfPeriod cycles; idle high, as the pin's pull-up leaves it
	always @(posedge clk) begin
		if (!run) begin
			kick <= 1'b1;
			cnt_r <= 8'h00;
		end else if (cnt_r >= halfPeriod - 8'h01) begin
			kick <= ~kick;
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule : kick_source
`default_nettype wire

// file: bench/supervisor_sva.sv
// Checker on the supervisor pins: fault pulse, reset delay and gating.
// Assumes the delay register keeps its parameter value during the run.
`timescale 1ns/1ns
`default_nettype none

module supervisor_sva #(
	parameter logic [31:0] DELAY_DEFAULT = 32'h38270,
	parameter logic [31:0] UPPER_DEFAULT = 32'h1bc560
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic watchdogInhibit,
	input wire logic windowTimeoutSel,
	input wire logic watchdogKickInput,
	input wire logic outputGood,
	input wire logic shutdownLockoutInput,
	input wire logic resetN,
	input wire logic watchdogFaultN
);
	logic [31:0] lowCnt_r;
	logic [31:0] goodCnt_r;
	logic [31:0] quietCnt_r;
	logic        kick_r;

	// Run lengths; counters instead of long repetitions keep the tools fast
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lowCnt_r <= '0;
			goodCnt_r <= '0;
			quietCnt_r <= '0;
			kick_r <= 1'b1;
		end else begin
			lowCnt_r <= watchdogFaultN ? '0 : lowCnt_r + 1;
			goodCnt_r <= (outputGood && shutdownLockoutInput) ? goodCnt_r + 1 : '0;
			quietCnt_r <= (watchdogKickInput != kick_r) ? '0 : quietCnt_r + 1;
			kick_r <= watchdogKickInput;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	AST_INHIBIT: assert property (watchdogInhibit [*6] |-> watchdogFaultN)
		else $error("fault output low while inhibited");
	AST_UV_RESET: assert property (!outputGood [*6] |-> !resetN)
		else $error("reset output high with output low");
	AST_SHUTDOWN: assert property (!shutdownLockoutInput [*6]
		|-> !resetN && watchdogFaultN)
		else $error("outputs active in shutdown");
	AST_FAULT_REL: assert property (!resetN [*2] |-> watchdogFaultN)
		else $error("fault output low while reset asserted");
	AST_FAULT_MAX: assert property (lowCnt_r <= DELAY_DEFAULT)
		else $error("fault pulse too long");
	AST_FAULT_LEN: assert property ($rose(watchdogFaultN) && resetN && !watchdogInhibit
		&& shutdownLockoutInput |-> lowCnt_r == DELAY_DEFAULT)
		else $error("fault pulse length wrong");
	AST_RESET_DELAY: assert property ($rose(resetN) |-> goodCnt_r > DELAY_DEFAULT
		&& goodCnt_r <= DELAY_DEFAULT + 6)
		else $error("reset release delay wrong");
	AST_LATE_ONLY: assert property ($fell(watchdogFaultN) && windowTimeoutSel
		|-> quietCnt_r >= UPPER_DEFAULT - 2)
		else $error("timeout mode fault before upper boundary");
endmodule : supervisor_sva

bind power_on_reset_watchdog_supervisor supervisor_sva #(
	.DELAY_DEFAULT(DELAY_DEFAULT),
	.UPPER_DEFAULT(UPPER_DEFAULT)
) sva (
	.clk, .rstn, .watchdogInhibit, .windowTimeoutSel, .watchdogKickInput,
	.outputGood, .shutdownLockoutInput, .resetN, .watchdogFaultN
);
`default_nettype wire

// file: bench/power_on_reset_watchdog_supervisor_tb.sv
// Bench for the supervisor: APB register access and pin scenarios.
// Assumes short counts handed to the top as parameters.
`timescale 1ns/1ns
`default_nettype none
`include "supervisor_defs.svh"

module power_on_reset_watchdog_supervisor_tb;
	localparam logic [31:0] DLY = 32'h14;
	localparam logic [31:0] UPR = 32'h190;
	localparam logic [31:0] LWR = 32'h50;
	logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, half = 8'h1e;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, err, kick, resetN, faultN, irq, run = 1'b0;
	logic        inhibit = 1'b0, sel = 1'b1, good = 1'b0, shut = 1'b1;
	int          nMismatch = 0, samplesChecked = 0, c, k;
	logic [7:0]  regAdr [4] = '{`SUP_REG_DELAY, `SUP_REG_UPPER, `SUP_REG_LOWER, `SUP_REG_MASK};
	logic [31:0] regRst [4] = '{DLY, UPR, LWR, 32'h0};

	power_on_reset_watchdog_supervisor #(
		.DELAY_DEFAULT(DLY),
		.UPPER_DEFAULT(UPR),
		.LOWER_DEFAULT(LWR)
	) dut (
		.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.watchdogInhibit(inhibit), .windowTimeoutSel(sel), .watchdogKickInput(kick),
		.outputGood(good), .shutdownLockoutInput(shut), .resetN, .watchdogFaultN(faultN), .irq
	);
	kick_source proc (.clk, .run, .halfPeriod(half), .kick);

	always #5 clk = ~clk;

	task automatic wrapUp;
		$display("mismatches %0d, comparisons %0d", nMismatch, samplesChecked);
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrapUp

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			nMismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer; the wait for pready is bounded so a dead slave ends the run
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk("pready", 1, 0);
			wrapUp();
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Edges until the chosen output shows level v: 0 resetN, 1 fault
	task automatic waitFor(input int s, input logic v, output int n);
		n = 0;
		while ((s == 0 ? resetN : faultN) !== v) begin
			@(posedge clk);
			n++;
			if (n > 2000) begin
				chk("wait bound", 1, 0);
				wrapUp();
			end
		end
	endtask : waitFor

	task automatic quiet(input int n);
		int lows;
		lows = 0;
		repeat (n) begin
			@(posedge clk);
			lows += int'(faultN !== 1'b1);
		end
		chk("fault low cycles", 0, lows);
	endtask : quiet

	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		chk("resetN before good", 0, resetN);
		good <= 1'b1;
		waitFor(0, 1'b1, c);
		chk("reset delay", 1, c > DLY && c <= DLY + 6);
		run <= 1'b1;
		for (k = 0; k < 4; k++) begin
			apb(1'b0, regAdr[k], 32'h0);
			chk("register reset value", regRst[k], rdat);
			chk("mapped error", 0, err);
		end
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 1, err);
		chk("unmapped data", 0, rdat);
		apb(1'b0, `SUP_REG_STATE, 32'h0);
		chk("state mode and reset", 32'h9, rdat & 32'h9);
		apb(1'b1, `SUP_REG_MASK, 32'h3);
		apb(1'b1, `SUP_REG_STATUS, 32'hf);
		// Timeout mode: quick kicks are fine, silence is a late fault
		quiet(600);
		run <= 1'b0;
		waitFor(1, 1'b0, c);
		chk("late fault time", 1, c >= UPR - 32 && c <= UPR + 8);
		waitFor(1, 1'b1, c);
		chk("fault pulse length", DLY, c);
		apb(1'b0, `SUP_REG_STATUS, 32'h0);
		chk("late status", 32'h2, rdat & 32'h2);
		chk("irq raised", 1, irq);
		apb(1'b1, `SUP_REG_STATUS, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq cleared", 0, irq);
		// Window mode: falling kicks 60 cycles apart are below the lower bound
		sel <= 1'b0;
		run <= 1'b1;
		waitFor(1, 1'b0, c);
		chk("early fault", 1, c < UPR);
		apb(1'b0, `SUP_REG_STATUS, 32'h0);
		chk("early status", 32'h1, rdat & 32'h1);
		run <= 1'b0;
		waitFor(1, 1'b1, c);
		half <= 8'h5a;
		run <= 1'b1;
		quiet(900);
		run <= 1'b0;
		waitFor(1, 1'b0, c);
		chk("window late fault", 1, c <= UPR + 8);
		inhibit <= 1'b1;
		repeat (10) @(posedge clk);
		quiet(900);
		inhibit <= 1'b0;
		waitFor(1, 1'b0, c);
		good <= 1'b0;
		waitFor(0, 1'b0, c);
		chk("undervoltage reset", 1, c <= 6);
		repeat (2) @(posedge clk);
		chk("fault released by reset", 1, faultN);
		apb(1'b0, `SUP_REG_STATUS, 32'h0);
		chk("undervoltage status", 32'h4, rdat & 32'hc);
		good <= 1'b1;
		waitFor(0, 1'b1, c);
		shut <= 1'b0;
		waitFor(0, 1'b0, c);
		chk("shutdown reset", 1, c <= 6);
		shut <= 1'b1;
		waitFor(0, 1'b1, c);
		chk("restart delay", 1, c > DLY && c <= DLY + 6);
		wrapUp();
	end
endmodule : power_on_reset_watchdog_supervisor_tb
`default_nettype wire
